// ==== src/ddr2_mode_pkg.sv ====
// Constants, types and encodings shared by the DDR2 mode register programmer.
// Assumes a single 250 MHz clock that also clocks the memory command bus.
// Summary of operation
// R1: Mode register write is all command pins low with BA1 and BA0 low.
// R2: Extended register 1 write is command pins low, BA0 high, BA1 low.
// R3: Extended register 2 write is command pins low, BA1 high, BA0 low.
// R4: Mode writes only with every bank precharged and CKE already high.
// R5: After each mode write wait the mode command cycle time before any command.
// R6: Every rewrite drives all fields of the register, not just changed ones.
// R7: Mode writes and DLL reset leave the memory array untouched.
// R8: Mode registers are undefined at power-up; each must be written first.
// R9: Mode bits A2..A0 pick burst length 4 or 8; A3 picks burst order.
// R10: Mode bits A6..A4 give CAS latency in whole clocks only.
// R11: Mode bit A7 test mode must be low; A8 high requests DLL reset.
// R12: Mode bits A11..A9 hold write recovery, ceiling of tWR over tCK.
// R13: BA2 and A15..A13 driven zero for mode and extended register 1.
// R14: Extended register 1 fields: DLL, drive, latency, termination, calibration, strobes.
// R15: Device disables DLL in self refresh and re-enables it on exit.
// R16: At least 200 clocks after DLL enable plus reset before any read.
// R17: Extended register 2 keeps only A7 high-temperature refresh; rest zero.
// R18: Extended register 3 write is BA2 low with BA1 and BA0 high.
// R19: Extended register 3 is written all zero apart from bank selects.
// R20: Each calibration command is followed by calibration exit; mode register set first.
// R21: Drive-high mode drives data and strobes high; drive-low the inverse.
// R22: Adjust mode takes its operation code as a burst of four.
// R23: Calibration code A9..A7: 000 exit, 001/010 drive, 100 adjust, 111 default.
// R24: Non-calibration extended register 1 writes carry 000 in A9..A7.
// R25: Burst length code 010 is four, 011 is eight, others reserved.
package ddr2_mode_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int T_CK_NS = 4;
  localparam int T_RP_NS = 15;
  localparam int RP_CK = (T_RP_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int T_WR_NS = 15;
  localparam int WR_CK = (T_WR_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int T_MRD_CK = 2;
  localparam int DLL_LOCK_CK = 200;
  localparam int ADJ_BEATS = 4;
  localparam int DQ_W = 8;
  // ************************************************************
  // Register map and control fields
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MR = 8'h04;
  localparam logic [7:0] ADDR_EMR3 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_CKE_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_OP_LSB = 2;
  localparam int CTRL_CAL_LSB = 8;
  localparam int CTRL_ADJ_LSB = 12;
  localparam logic [2:0] OP_CAL = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // Mode register encodings
  // ************************************************************
  localparam logic [1:0] SEL_MR = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;
  localparam logic [1:0] SEL_EMR2 = 2'h2;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam int MR_TEST_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int EMR1_DLL_OFF_BIT = 0;
  localparam int EMR2_HTSR_BIT = 7;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DRIVE1 = 3'h1;
  localparam logic [2:0] OCD_DRIVE0 = 3'h2;
  localparam logic [2:0] OCD_ADJUST = 3'h4;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;

  typedef enum logic [2:0] {ST_IDLE, ST_PRE_WAIT, ST_MRD_WAIT, ST_ADJ_WAIT, ST_ADJ_BURST} state_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } ddr_cmd_type;

  localparam ddr_cmd_type CMD_NOP = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 3'h0, addr: 16'h0000};
  localparam ddr_cmd_type CMD_PREALL = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b1, we_n: 1'b0, ba: 3'h0, addr: 16'h0400};
endpackage

// ==== src/ddr2_mode_ctrl.sv ====
// DDR2 mode register programmer: AXI4-Lite slave in, DDR2 command pins out.
// Assumes CLK also clocks the memory, and the bus above waits for answers.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module ddr2_mode_ctrl
  import ddr2_mode_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Memory command bus
  output ddr_cmd_type DDR_CMD,
  output logic DDR_CKE,
  // Data pins used only for the adjust burst
  output logic [DQ_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  output logic DQS_OUT,
  output logic DQS_OE_N
);

  typedef struct packed {
    state_type st;
    logic [7:0] cnt;
    logic [15:0] ctrl;
    logic [3:0][15:0] shadow;
    logic [3:0] written;
    logic [7:0] dll_cnt;
    logic dll_ready;
    logic err;
    logic [1:0] sel;
    logic cal;
    logic [2:0] cal_code;
    logic [1:0] beat;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ddr_cmd_type cmd;
    logic [DQ_W-1:0] dq;
    logic dq_oe_n;
    logic dqs;
  } regs_type;

  regs_type r;
  regs_type n;
  logic go;
  logic err_set;
  logic [2:0] op;
  logic [3:0] wl;
  ddr_cmd_type mcmd;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        v[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // Shadow registers sit at consecutive words after the control word
  function automatic logic shadow_hit(input logic [7:0] a);
    return (a >= ADDR_MR) && (a <= ADDR_EMR3) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [1:0] shadow_idx(input logic [7:0] a);
    return 2'(a[4:2] - 3'h1);
  endfunction

  // Whole register is always rebuilt from the shadow, reserved fields forced
  function automatic ddr_cmd_type mode_cmd(input logic [1:0] sel, input logic [3:0][15:0] sh,
                                           input logic [2:0] code);
    ddr_cmd_type c;
    logic [15:0] v;
    v = 16'h0000;
    case (sel)
      SEL_MR:
      begin
        v = sh[0]; // R6
        v[MR_TEST_BIT] = 1'b0; // R11
        v[11:9] = 3'(WR_CK); // R12
      end
      SEL_EMR1:
      begin
        v = sh[1]; // R6
        v[9:7] = code; // R24
      end
      SEL_EMR2:
      begin
        v[EMR2_HTSR_BIT] = sh[2][EMR2_HTSR_BIT]; // R17
      end
      default:
      begin
        v = 16'h0000; // R19
      end
    endcase
    v[15:13] = 3'h0; // R13
    c.cs_n = 1'b0;
    c.ras_n = 1'b0;
    c.cas_n = 1'b0;
    c.we_n = 1'b0;
    c.ba = {1'b0, sel}; // R1 R2 R3 R18 R13
    c.addr = v;
    return c;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    n = r;
    go = 1'b0;
    err_set = 1'b0;
    op = r.ctrl[CTRL_OP_LSB +: 3];
    mcmd = mode_cmd(r.sel, r.shadow, r.cal_code);
    wl = 4'({1'b0, r.shadow[1][5:3]} + {1'b0, r.shadow[0][6:4]} - 4'h1);
    // A zero sum wraps to 4'hF, so both ends are clamped to one
    if (wl == 4'h0 || wl == 4'hF)
    begin
      wl = 4'h1;
    end
    n.cmd = CMD_NOP;
    n.dq = '0;
    n.dq_oe_n = 1'b1;
    n.dqs = 1'b0;

    // Bus write: address and data are taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      n.aw_held = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      n.w_held = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      n.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid)
    begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (r.awaddr == ADDR_CTRL)
      begin
        n.ctrl = 16'(wmerge({16'h0000, r.ctrl}, r.wdata, r.wstrb));
        n.ctrl[CTRL_GO_BIT] = 1'b0;
        go = r.wstrb[0] && r.wdata[CTRL_GO_BIT];
        op = r.wdata[CTRL_OP_LSB +: 3];
      end
      else if (shadow_hit(r.awaddr))
      begin
        n.shadow[shadow_idx(r.awaddr)] = 16'(wmerge({16'h0000, r.shadow[shadow_idx(r.awaddr)]}, r.wdata, r.wstrb));
      end
      else if (r.awaddr != ADDR_STATUS)
      begin
        n.bresp = RESP_SLVERR;
      end
    end

    // Bus read
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (S_AXI_ARADDR == ADDR_CTRL)
      begin
        n.rdata[15:0] = r.ctrl;
      end
      else if (shadow_hit(S_AXI_ARADDR))
      begin
        n.rdata[15:0] = r.shadow[shadow_idx(S_AXI_ARADDR)];
      end
      else if (S_AXI_ARADDR == ADDR_STATUS)
      begin
        n.rdata[6:0] = {r.err, r.dll_ready, r.written, r.st != ST_IDLE};
      end
      else
      begin
        n.rresp = RESP_SLVERR;
      end
    end

    // Start checks; the order bits come from the same write as go
    if (go)
    begin
      if (r.st != ST_IDLE || !n.ctrl[CTRL_CKE_BIT] || op > OP_CAL) // R4
      begin
        err_set = 1'b1;
      end
      if (op == OP_CAL && !r.written[SEL_MR]) // R20
      begin
        err_set = 1'b1;
      end
      if (op == OP_CAL && n.ctrl[CTRL_CAL_LSB +: 3] == OCD_ADJUST && r.shadow[0][2:0] != BL4_CODE) // R22 R25
      begin
        err_set = 1'b1;
      end
    end
    // A new order clears the error, but its own fault still sets it
    n.err = (go ? 1'b0 : r.err) | err_set;

    if (r.dll_cnt != 8'h00)
    begin
      n.dll_cnt = 8'(r.dll_cnt - 8'h01);
      if (r.dll_cnt == 8'h01)
      begin
        n.dll_ready = 1'b1; // R16
      end
    end
    if (r.cnt != 8'h00)
    begin
      n.cnt = 8'(r.cnt - 8'h01);
    end

    case (r.st)
      ST_IDLE:
      begin
        if (go && !err_set)
        begin
          n.cal = (op == OP_CAL);
          n.sel = (op == OP_CAL) ? SEL_EMR1 : op[1:0];
          n.cal_code = (op == OP_CAL) ? n.ctrl[CTRL_CAL_LSB +: 3] : OCD_EXIT;
          // Banks may hold open rows from other traffic, so close them all
          n.cmd = CMD_PREALL; // R4
          n.cnt = 8'(RP_CK - 1);
          n.st = ST_PRE_WAIT;
        end
      end
      ST_PRE_WAIT:
      begin
        if (r.cnt == 8'h00)
        begin
          n.cmd = mcmd;
          n.written[r.sel] = 1'b1; // R8
          if (r.sel == SEL_MR && mcmd.addr[MR_DLLRST_BIT] && r.written[SEL_EMR1]
              && !r.shadow[1][EMR1_DLL_OFF_BIT])
          begin
            n.dll_cnt = 8'(DLL_LOCK_CK); // R16
            n.dll_ready = 1'b0;
          end
          if (r.sel == SEL_EMR1 && mcmd.addr[EMR1_DLL_OFF_BIT])
          begin
            n.dll_cnt = 8'h00;
            n.dll_ready = 1'b0;
          end
          if (r.cal && r.cal_code == OCD_ADJUST)
          begin
            n.cnt = 8'(wl - 4'h1);
            n.st = ST_ADJ_WAIT;
          end
          else
          begin
            n.cnt = 8'(T_MRD_CK - 1); // R5
            n.st = ST_MRD_WAIT;
          end
        end
      end
      ST_MRD_WAIT:
      begin
        if (r.cnt == 8'h00)
        begin
          if (r.cal && r.cal_code != OCD_EXIT)
          begin
            // Drive and default modes end at once; no other command in between
            n.cal_code = OCD_EXIT; // R20 R24
            n.cmd = mode_cmd(SEL_EMR1, r.shadow, OCD_EXIT); // R20
            n.cnt = 8'(T_MRD_CK - 1); // R5
          end
          else
          begin
            n.st = ST_IDLE;
          end
        end
      end
      ST_ADJ_WAIT:
      begin
        if (r.cnt == 8'h00)
        begin
          n.beat = 2'h0;
          n.dq = {DQ_W{r.ctrl[CTRL_ADJ_LSB]}}; // R22
          n.dq_oe_n = 1'b0;
          n.dqs = 1'b1;
          n.st = ST_ADJ_BURST;
        end
      end
      ST_ADJ_BURST:
      begin
        // One beat per CLK: the code is held a full cycle, not a half
        if (r.beat == 2'(ADJ_BEATS - 1))
        begin
          n.cnt = 8'h00;
          n.st = ST_MRD_WAIT;
        end
        else
        begin
          n.beat = 2'(r.beat + 2'h1);
          n.dq = {DQ_W{r.ctrl[CTRL_ADJ_LSB + int'(n.beat)]}}; // R22
          n.dq_oe_n = 1'b0;
          n.dqs = ~n.beat[0];
        end
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.cmd <= CMD_NOP;
      r.dq_oe_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign S_AXI_AWREADY = !r.aw_held && !r.bvalid;
  assign S_AXI_WREADY = !r.w_held && !r.bvalid;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = !r.rvalid;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;
  assign DDR_CMD = r.cmd;
  assign DDR_CKE = r.ctrl[CTRL_CKE_BIT];
  assign DQ_OUT = r.dq;
  assign DQ_OE_N = r.dq_oe_n;
  assign DQS_OUT = r.dqs;
  assign DQS_OE_N = r.dq_oe_n;

endmodule

// ==== tb/ddr2_mode_ctrl_asserts.sv ====
// Checker on the memory command pins of the mode register programmer.
// Assumes it is bound into ddr2_mode_ctrl and sees only its ports.
`timescale 1ns/10ps
module ddr2_mode_ctrl_asserts
  import ddr2_mode_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Memory side
  input wire ddr_cmd_type DDR_CMD,
  input wire logic DDR_CKE,
  input wire logic DQ_OE_N,
  input wire logic DQS_OUT,
  input wire logic DQS_OE_N
);
  logic mrs;
  assign mrs = ~|{DDR_CMD.cs_n, DDR_CMD.ras_n, DDR_CMD.cas_n, DDR_CMD.we_n};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ********
  // Command spacing
  // ********
  pre_gap_a: assert property (DDR_CMD == CMD_PREALL |-> ##4 mrs)
    else $error("mode write not four cycles after precharge all");
  mrd_nop_a: assert property (mrs |=> DDR_CMD == CMD_NOP)
    else $error("command inside mode command cycle time");
  cke_high_a: assert property (mrs |-> DDR_CKE)
    else $error("mode write with clock enable low");
  // ********
  // Register contents
  // ********
  rsv_zero_a: assert property (mrs |-> !DDR_CMD.ba[2] && DDR_CMD.addr[15:13] == 3'h0)
    else $error("reserved bank or address bits set");
  mr_fields_a: assert property (mrs && DDR_CMD.ba == 3'h0
    |-> !DDR_CMD.addr[7] && DDR_CMD.addr[11:9] == 3'(WR_CK))
    else $error("bad test mode or write recovery");
  emr2_only_a: assert property (mrs && DDR_CMD.ba == 3'h2 |-> (DDR_CMD.addr & 16'hFF7F) == 16'h0000)
    else $error("extended register 2 carries stray bits");
  emr3_zero_a: assert property (mrs && DDR_CMD.ba == 3'h3 |-> DDR_CMD.addr == 16'h0000)
    else $error("extended register 3 not zero");
  // ********
  // Calibration
  // ********
  cal_exit_a: assert property (mrs && DDR_CMD.ba == 3'h1 && DDR_CMD.addr[9:7] != OCD_EXIT
    |-> ##[2:20] (mrs && DDR_CMD.ba == 3'h1 && DDR_CMD.addr[9:7] == OCD_EXIT))
    else $error("calibration command without exit");
  adj_len_a: assert property ($fell(DQ_OE_N) |-> (!DQ_OE_N) [*4] ##1 DQ_OE_N)
    else $error("adjust burst not four beats");
  dqs_walk_a: assert property ($fell(DQ_OE_N) |-> DQS_OUT ##1 !DQS_OUT ##1 DQS_OUT ##1 !DQS_OUT)
    else $error("strobe pattern wrong in adjust burst");
  dqs_oe_a: assert property (DQS_OE_N == DQ_OE_N)
    else $error("strobe enable differs from data enable");
endmodule

bind ddr2_mode_ctrl ddr2_mode_ctrl_asserts chk_u (.CLK(CLK), .RST(RST), .DDR_CMD(DDR_CMD),
  .DDR_CKE(DDR_CKE), .DQ_OE_N(DQ_OE_N), .DQS_OUT(DQS_OUT), .DQS_OE_N(DQS_OE_N));

// ==== tb/ddr2_dev_model.sv ====
// Behavioural DDR2 device: decodes mode writes, counts command faults.
// Assumes it shares the controller clock and watches its pins only.
`timescale 1ns/10ps
module ddr2_dev_model
  import ddr2_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins from the controller
  input wire ddr_cmd_type cmd,
  input wire logic cke,
  input wire logic [DQ_W-1:0] dq,
  input wire logic dq_oe_n,
  // Observed state
  output logic [3:0][15:0] regs,
  output logic [3:0] seen,
  output logic [2:0] ocd,
  output logic [2:0] ocd_last,
  output logic [3:0] adj,
  output logic [3:0] blen,
  output logic [7:0] bad
);
  logic mrs, mrd, chg, lastpre;
  logic oe_q;
  logic [3:0] wl;
  int gap;
  // Adjust data is expected additive plus CAS latency, less one, after the command
  assign wl = 4'({1'b0, regs[1][5:3]} + {1'b0, regs[0][6:4]} - 4'h1);
  // No self refresh is ever issued, so the DLL only follows mode writes
  assign mrs = ~|{cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
  // No array kept: mode writes cannot disturb data here
  assign blen = regs[0][2:0] == BL4_CODE ? 4'h4 : (regs[0][2:0] == 3'h3 ? 4'h8 : 4'h0);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seen <= 4'h0;
      bad <= 8'h00;
      {mrd, chg, lastpre} <= 3'h0;
      gap <= 0;
      oe_q <= 1'b1;
      ocd <= OCD_EXIT;
      ocd_last <= OCD_EXIT;
      adj <= 4'h0;
    end
    else
    begin
      gap <= gap + 1;
      oe_q <= dq_oe_n;
      if (!dq_oe_n)
        adj <= {dq[0], adj[3:1]};
      if (!dq_oe_n && oe_q && gap != int'(wl) - 1)
        bad <= bad + 8'h01;
      if (cmd != CMD_NOP)
      begin
        gap <= 0;
        mrd <= mrs;
        lastpre <= cmd == CMD_PREALL;
        chg <= chg | (cmd == CMD_PREALL);
        if ((mrd && gap < T_MRD_CK - 1) || (mrs && (!chg || !cke || (lastpre && gap < RP_CK - 1))))
          bad <= bad + 8'h01;
        else if (ocd != OCD_EXIT && !(mrs && cmd.ba == 3'h1 && cmd.addr[9:7] == OCD_EXIT))
          bad <= bad + 8'h01;
        if (mrs)
        begin
          regs[cmd.ba[1:0]] <= cmd.addr;
          seen[cmd.ba[1:0]] <= 1'b1;
          if (cmd.ba[1:0] == SEL_EMR1)
            ocd <= cmd.addr[9:7];
          if (cmd.ba[1:0] == SEL_EMR1 && cmd.addr[9:7] != OCD_EXIT)
            ocd_last <= cmd.addr[9:7];
        end
      end
    end
  end
endmodule

// ==== tb/ddr2_mode_ctrl_tb_top.sv ====
// Self-checking bench: AXI4-Lite master, device model and scenarios.
// Assumes the bound checker and ddr2_dev_model are compiled alongside.
`timescale 1ns/10ps
module ddr2_mode_ctrl_tb_top
  import ddr2_mode_pkg::*;
;
  logic clk, rst, awv, wv, bre, arv, rre, aw_rdy, w_rdy, bv, ar_rdy, rv, oe_n, dqs_oe_n, dqs, cke;
  logic [7:0] awa, ara, bad;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [DQ_W-1:0] dq;
  ddr_cmd_type cmd;
  logic [3:0][15:0] regs;
  logic [3:0] seen, adj, blen, strb;
  logic [2:0] ocd, ocd_last;
  int mismatches, compares;
  ddr2_mode_ctrl dut_u (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .DDR_CMD(cmd), .DDR_CKE(cke),
    .DQ_OUT(dq), .DQ_OE_N(oe_n), .DQS_OUT(dqs), .DQS_OE_N(dqs_oe_n));
  ddr2_dev_model dev_u (.clk(clk), .rst(rst), .cmd(cmd), .cke(cke), .dq(dq), .dq_oe_n(oe_n),
    .regs(regs), .seen(seen), .ocd(ocd), .ocd_last(ocd_last), .adj(adj), .blen(blen), .bad(bad));
  // ********
  // Bus and report tasks
  // ********
  task automatic check(input logic [31:0] v, input logic [31:0] e);
    compares++;
    if (v !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, v, e);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    end_of_test;
  endtask
  // Answers are sampled mid-cycle; nothing changes until the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_ok, w_ok, b_ok;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    {awv, wv, bre} <= 3'h7;
    do
    begin
      @(negedge clk);
      {a_ok, w_ok, b_ok, r} = {aw_rdy, w_rdy, bv, br};
      @(posedge clk);
      if (a_ok)
        awv <= 1'b0;
      if (w_ok)
        wv <= 1'b0;
      n++;
    end
    while (!b_ok && n < 100);
    bre <= 1'b0;
    if (!b_ok)
      hang;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_ok, r_ok;
    n = 0;
    @(posedge clk);
    ara <= a;
    {arv, rre} <= 2'h3;
    do
    begin
      @(negedge clk);
      {a_ok, r_ok, d, r} = {ar_rdy, rv, rdat, rr};
      @(posedge clk);
      if (a_ok)
        arv <= 1'b0;
      n++;
    end
    while (!r_ok && n < 100);
    rre <= 1'b0;
    if (!r_ok)
      hang;
  endtask
  function automatic logic [31:0] cw(input logic [2:0] op, input logic [2:0] cal, input logic [3:0] a);
    return {16'h0, a, 1'b0, cal, 3'h0, op, 2'h3};
  endfunction
  task automatic go(input logic [31:0] c, output logic [31:0] s);
    int n;
    logic [1:0] r;
    wr(ADDR_CTRL, c, r);
    n = 0;
    do
    begin
      rd(ADDR_STATUS, s, r);
      n++;
    end
    while (s[0] !== 1'b0 && n < 50);
    if (s[0] !== 1'b0)
      hang;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] refused [3] = '{cw(3'h4, 3'h0, 4'h0), 32'h2, cw(3'h5, 3'h0, 4'h0)};
    rd(ADDR_STATUS, d, r);
    check(d, 32'h0);
    rd(8'h40, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_STATUS, 32'hFFFFFFFF, r);
    check(32'(r), 32'(RESP_OKAY));
    // Only the strobed byte of a shadow may change
    strb <= 4'h1;
    wr(ADDR_MR, 32'h1234_5678, r);
    rd(ADDR_MR, d, r);
    check(d, 32'h78);
    strb <= 4'hF;
    foreach (refused[i])
    begin
      go(refused[i], d);
      check(d & 32'h40, 32'h40);
      check(32'(seen), 32'h0);
    end
    $display("t_bus done");
  endtask
  task automatic t_modes;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] e;
    logic [15:0] sh [4] = '{16'hFFB2, 16'hFFC6, 16'hFFFF, 16'hFFFF};
    logic [15:0] km [4] = '{16'h117F, 16'h1C7F, 16'h0080, 16'h0000};
    int ops [4] = '{1, 2, 3, 0};
    foreach (ops[i])
    begin
      wr(ADDR_MR + 8'(4 * ops[i]), {16'hABCD, sh[ops[i]]}, r);
      rd(ADDR_MR + 8'(4 * ops[i]), d, r);
      check(d, {16'h0, sh[ops[i]]});
      go(cw(3'(ops[i]), 3'h0, 4'h0), d);
      e = sh[ops[i]] & km[ops[i]];
      if (ops[i] == 0)
        e[11:9] = 3'(WR_CK);
      check(32'(regs[ops[i]]), 32'(e));
    end
    check(d, 32'h1E);
    check(32'(blen), 32'h4);
    repeat (DLL_LOCK_CK) @(posedge clk);
    rd(ADDR_STATUS, d, r);
    check(d, 32'h3E);
    $display("t_modes done");
  endtask
  task automatic t_cal;
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] codes [4] = '{OCD_DRIVE1, OCD_DRIVE0, OCD_DEFAULT, OCD_ADJUST};
    foreach (codes[i])
    begin
      go(cw(3'h4, codes[i], 4'h4), d);
      check(32'(ocd_last), 32'(codes[i]));
      check(32'(ocd), 32'(OCD_EXIT));
    end
    check(32'(adj), 32'h4);
    // Turning the DLL off must withdraw the ready flag
    wr(ADDR_MR + 8'h04, 32'h0000_FFC7, r);
    go(cw(3'h1, 3'h0, 4'h0), d);
    check(32'(regs[1][9:7]), 32'(OCD_EXIT));
    check(32'(regs[1][0]), 32'h1);
    check(d & 32'h20, 32'h0);
    check(32'(bad), 32'h0);
    $display("t_cal done");
  endtask
  // ********
  // Clock, reset and sequence
  // ********
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst, awv, wv, bre, arv, rre} = 6'h20;
    {awa, ara, wd} = 48'h0;
    strb = 4'hF;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_bus;
    t_modes;
    t_cal;
    end_of_test;
  end
endmodule
